/* File: tb/art_pin_model.sv */
/* External event source at the timer's event pin.
   Assumes the bench calls pulse from its main sequence. */
`timescale 1ns/1ps
module art_pin_model (
  // Clock
  input wire logic ref_clk,
  // Event pin
  output logic     extEvent
);
  initial extEvent = 1'b0;
  // A gap after each event keeps every rising edge distinct
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge ref_clk) extEvent <= 1'b1;
      @(posedge ref_clk) extEvent <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: tb/art_timer_properties.sv */
/* Port-level assertions for art_timer.
   Assumes one clock domain; bound to every art_timer instance. */
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer_properties (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst,
  // Bus
  input wire art_pkg::art_wbreq_t wbReq,
  input wire logic [31:0]         wbDatO,
  input wire logic                wbAck,
  // Pins and power modes
  input wire logic                haltMode,
  input wire logic                waitMode,
  input wire logic [3:0]          pwmOutPin,
  input wire logic [3:0]          pwmOutPinOe,
  input wire logic                irqReq,
  input wire logic                wakeReq
);
  import art_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire take = wbReq.cyc && wbReq.stb && !wbAck;
  sequence csrRd;
    take && !wbReq.we && wbReq.adr == `ART_OFF_CSR;
  endsequence
  ack_timing_a: assert property (take |=> wbAck) else $error("ack late");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
  unmapped_zero_a: assert property (
    wbAck && !wbReq.we && wbReq.adr > `ART_OFF_DCR3 |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  reload_bit_a: assert property (
    wbAck && !wbReq.we && wbReq.adr == `ART_OFF_CSR |-> !wbDatO[`ART_BIT_FORCE_RELOAD])
    else $error("force reload bit read back");
  flag_read_a: assert property (csrRd ##0 irqReq |=> wbAck && wbDatO[`ART_BIT_OVF])
    else $error("flag not read as set");
  irq_hold_a: assert property (irqReq && !take |=> irqReq) else $error("request dropped");
  halt_freeze_a: assert property (haltMode && !wbReq.stb |=> $stable(pwmOutPin))
    else $error("pins moved in halt");
  pin_gate_a: assert property ((pwmOutPin & ~pwmOutPinOe) == 4'h0)
    else $error("disabled pin driven");
  wake_level_a: assert property (wakeReq == (irqReq && (waitMode || haltMode)))
    else $error("wake request wrong");
endmodule
bind art_timer art_timer_properties props (.ref_clk(ref_clk), .rst(rst), .wbReq(wbReq),
  .wbDatO(wbDatO), .wbAck(wbAck), .haltMode(haltMode), .waitMode(waitMode),
  .pwmOutPin(pwmOutPin), .pwmOutPinOe(pwmOutPinOe), .irqReq(irqReq), .wakeReq(wakeReq));

/* File: tb/test_auto_reload_pwm_timer.sv */
/* Self-checking bench for art_timer with an event-source model.
   Assumes the checker is bound and art_params.svh is on the path. */
`timescale 1ns/1ps
`include "art_params.svh"
module test_auto_reload_pwm_timer;
  import art_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, haltMode = 1'b0, waitMode = 1'b0;
  art_wbreq_t wbReq = '0;
  logic [31:0] wbDatO, q, seed = 32'd71039;
  logic       wbAck, irqReq, wakeReq, extEvent;
  logic [3:0] pwmOutPin, pwmOutPinOe;
  int         nMismatch = 0, samplesChecked = 0, hi, per, r, d;
  always #12.5 ref_clk = ~ref_clk;
  art_timer dut (.ref_clk(ref_clk), .rst(rst), .wbReq(wbReq), .wbDatO(wbDatO),
    .wbAck(wbAck), .extEvent(extEvent), .haltMode(haltMode), .waitMode(waitMode),
    .pwmOutPin(pwmOutPin), .pwmOutPinOe(pwmOutPinOe), .irqReq(irqReq), .wakeReq(wakeReq));
  art_pin_model load (.ref_clk(ref_clk), .extEvent(extEvent));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    int t = 0;
    @(posedge ref_clk) wbReq <= '{1'b1, 1'b1, w, 4'hF, a, {24'h0, v}};
    // Ack and read data are taken at the rising edge; release follows at that same edge
    do @(posedge ref_clk); while (wbAck !== 1'b1 && ++t < 50);
    if (wbAck !== 1'b1) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, wbAck, 1'b1);
    end
    q = wbDatO;
    wbReq <= '0;
  endtask
  // First edge may be mid-pulse, so sync to a full low then rise
  task automatic measure(input int ch);
    int t;
    @(negedge ref_clk);
    for (t = 0; t < 3000 && pwmOutPin[ch] !== 1'b0; t++) @(negedge ref_clk);
    for (t = 0; t < 3000 && pwmOutPin[ch] !== 1'b1; t++) @(negedge ref_clk);
    for (hi = 0; pwmOutPin[ch] === 1'b1 && hi < 3000; hi++) @(negedge ref_clk);
    for (per = hi; pwmOutPin[ch] === 1'b0 && per < 3000; per++) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    nMismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a <= 8; a++) begin
      bus(1'b0, 8'(4 * a), 8'h00);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      r = 240 + int'(xs() & 7);
      d = r + 1 + int'(xs() % (254 - r));
      bus(1'b1, `ART_OFF_ARR, 8'(r));
      bus(1'b1, 8'(`ART_OFF_DCR0 + 4 * i), 8'(d));
      bus(1'b1, `ART_OFF_PWM_CONTROL_REG, 8'((16 << i) | ((i % 2) << i)));
      bus(1'b1, `ART_OFF_CSR, 8'((i << 4) | 8'h0E));
      measure(i);
      measure(i);
      chk(per, (256 - r) << i);
      chk(hi, (i % 2 ? 255 - d : d - r + 1) << i);
    end
    bus(1'b0, `ART_OFF_CSR, 8'h00);
    chk(q, 32'h3B);
    bus(1'b1, `ART_OFF_CSR, 8'h02);
    bus(1'b0, `ART_OFF_CSR, 8'h00);
    bus(1'b0, `ART_OFF_CSR, 8'h00);
    chk(q, 32'h02);
    chk(irqReq, 32'h0);
    bus(1'b1, `ART_OFF_CAR, 8'h5A);
    repeat (20) @(posedge ref_clk);
    bus(1'b0, `ART_OFF_CAR, 8'h00);
    chk(q, 32'h5A);
    bus(1'b1, `ART_OFF_ARR, 8'hFD);
    bus(1'b1, `ART_OFF_CSR, 8'h8C);
    load.pulse(2);
    bus(1'b0, `ART_OFF_CSR, 8'h00);
    chk(q, 32'h88);
    load.pulse(1);
    bus(1'b0, `ART_OFF_CSR, 8'h00);
    chk(q, 32'h89);
    bus(1'b1, `ART_OFF_CSR, 8'h0A);
    haltMode <= 1'b1;
    waitMode <= ^xs();
    bus(1'b1, `ART_OFF_CAR, 8'h33);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, `ART_OFF_CAR, 8'h00);
    chk(q, 32'h33);
    haltMode <= 1'b0;
    give_verdict();
  end
endmodule

/* File: verilog/art_params.svh */
/*
  Register offsets, field positions, reset values and counts for the auto-reload PWM timer.
  Assumes inclusion by bare name from the design file, the checker and the bench.
*/
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH
`define ART_OFF_CSR      8'h00
`define ART_OFF_CAR      8'h04
`define ART_OFF_ARR      8'h08
`define ART_OFF_PWM_CONTROL_REG    8'h0C
`define ART_OFF_DCR0     8'h10
`define ART_OFF_DCR1     8'h14
`define ART_OFF_DCR2     8'h18
`define ART_OFF_DCR3     8'h1C
`define ART_BIT_EXT_CLOCK_SELECT     7
`define ART_BIT_TCE      3
`define ART_BIT_FORCE_RELOAD     2
`define ART_BIT_OIE      1
`define ART_BIT_OVF      0
`define ART_CC_HI        6
`define ART_CC_LO        4
`define ART_RST_BYTE     8'h00
`define ART_PRE_ZERO     7'h00
`define ART_PRE_ONE      7'h01
`define ART_CNT_ONE      8'h01
`define ART_CNT_MAX      8'hFF
`define ART_NCH          4
`define ART_UNMAPPED     32'h0000_0000
`endif

/* File: verilog/art_pkg.sv */
/*
  Types shared by the auto-reload PWM timer.
  Assumes art_params.svh is on the include path.
*/
package art_pkg;
  typedef struct packed {
    logic       extClockSelect;
    logic [2:0] counterClockDivider;
    logic       countEnableBit;
    logic       overflowIrqEnable;
  } art_ctrl_t;

  typedef struct packed {
    logic [3:0] channelOutputEnable;
    logic [3:0] channelPolarity;
  } art_pwmctl_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } art_wbreq_t;
endpackage

/* File: verilog/art_timer.sv */
/*
  Auto-reload PWM timer: 7-bit prescaler, 8-bit reload counter, four PWM channels,
  overflow flag and request, reached over a classic Wishbone slave.
  Assumes extEvent, haltMode and waitMode are synchronous to ref_clk.
*/
// Our own choices: the placing of the registers and register access over Wishbone.
// Operation
// - Eight-bit counter steps up on each prescaler output tick.
// - Software reads or writes the live counter while it runs.
// - Overflow reloads counter from reload value; prescaler left alone.
// - Seven-bit prescaler, eight taps, divide by two to the divider field.
// - Prescaler input is CPU clock or external input by select bit.
// - Count enable clear freezes prescaler and counter; set runs them.
// - Reset clears counter and prescaler and selects CPU clock.
// - Force reload or counter write loads counter and clears prescaler.
// - Prescaler has no software read or write path.
// - Four hidden compare registers load from duty registers at overflow.
// - Channel enable drives its pin push-pull with the PWM wave.
// - All channels share period of counter clock over 256 minus reload.
// - At overflow each enabled pin takes the inverse of its polarity bit.
// - Counter reaching compare value returns pin to opposite level.
// - Reload zero gives 1/256 resolution; polarity gives 0 or 100 percent.
// - PWM generation stops in HALT mode.
// - Overflow sets flag and raises request when enabled.
// - External input turns timer into an event counter.
// - Timer can request wake-up from WAIT and HALT.
// - Reading the control/status register clears the overflow flag.
// - Polarity 0 drives 1 while counter at or below compare, else 0.
// - Polarity change inverts output at once.
// - Force reload is write-only and reads as zero.
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire art_pkg::art_wbreq_t wbReq,
  output logic [31:0]            wbDatO,
  output logic                   wbAck,
  // Pins and power modes
  input  wire logic              extEvent,
  input  wire logic              haltMode,
  input  wire logic              waitMode,
  output logic [3:0]             pwmOutPin,
  output logic [3:0]             pwmOutPinOe,
  output logic                   irqReq,
  output logic                   wakeReq
);
  import art_pkg::*;

  art_ctrl_t   ctrl_r;
  art_pwmctl_t pwmCtl_r;
  logic        overflowFlag_r;
  logic [7:0]  counter_r;
  logic [7:0]  reload_r;
  logic [6:0]  prescaler_r;
  logic [6:0]  prescalerNxt;
  logic        extPrev_r;
  logic        inputTick;
  logic        counterTick;
  logic        overflow;
  logic [7:0]  dutyReg_r    [`ART_NCH];
  logic [7:0]  hiddenCmp_r  [`ART_NCH];
  logic [3:0]  waveRaw_r;
  logic        access;
  logic        wrStb;
  logic        rdStb;
  logic        forceReload;
  logic        carWrite;
  logic [31:0] rdData;

  // One access per request; ack drops the cycle after it was given
  assign access = wbReq.cyc && wbReq.stb && !wbAck;
  assign wrStb  = access && wbReq.we && wbReq.sel[0];
  assign rdStb  = access && !wbReq.we;

  assign forceReload = wrStb && (wbReq.adr == `ART_OFF_CSR) && wbReq.dat[`ART_BIT_FORCE_RELOAD];
  assign carWrite    = wrStb && (wbReq.adr == `ART_OFF_CAR);

  // External events counted on rising edge of the sampled input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= extEvent;
    end
  end

  // HALT stops both the CPU clock and external clock paths, and so PWM generation
  always_comb begin
    if (ctrl_r.extClockSelect) begin
      inputTick = extEvent && !extPrev_r && !haltMode;
    end else begin
      inputTick = !haltMode;
    end
  end

  assign prescalerNxt = prescaler_r + `ART_PRE_ONE;

  // Tap n ticks when the low n prescaler bits wrap to zero
  always_comb begin
    counterTick = 1'b0;
    if (ctrl_r.countEnableBit && inputTick) begin
      if (ctrl_r.counterClockDivider == 3'h0) begin
        counterTick = 1'b1;
      end else begin
        counterTick = (prescalerNxt & ((`ART_PRE_ONE << ctrl_r.counterClockDivider)
                       - `ART_PRE_ONE)) == `ART_PRE_ZERO;
      end
    end
  end

  assign overflow = counterTick && (counter_r == `ART_CNT_MAX) && !forceReload && !carWrite;

  // Prescaler: no software path except clearing on initialisation
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prescaler_r <= `ART_PRE_ZERO;
    end else if (forceReload || carWrite) begin
      prescaler_r <= `ART_PRE_ZERO;
    end else if (ctrl_r.countEnableBit && inputTick) begin
      prescaler_r <= prescalerNxt;
    end
  end

  // Counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counter_r <= `ART_RST_BYTE;
    end else if (carWrite) begin
      counter_r <= wbReq.dat[7:0];
    end else if (forceReload) begin
      counter_r <= reload_r;
    end else if (overflow) begin
      counter_r <= reload_r;
    end else if (counterTick) begin
      counter_r <= counter_r + `ART_CNT_ONE;
    end
  end

  // Control, reload and channel setup registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= '0;
      reload_r <= `ART_RST_BYTE;
      pwmCtl_r <= '0;
    end else if (wrStb) begin
      if (wbReq.adr == `ART_OFF_CSR) begin
        ctrl_r.extClockSelect      <= wbReq.dat[`ART_BIT_EXT_CLOCK_SELECT];
        ctrl_r.counterClockDivider <= wbReq.dat[`ART_CC_HI:`ART_CC_LO];
        ctrl_r.countEnableBit      <= wbReq.dat[`ART_BIT_TCE];
        ctrl_r.overflowIrqEnable   <= wbReq.dat[`ART_BIT_OIE];
      end
      if (wbReq.adr == `ART_OFF_ARR) begin
        reload_r <= wbReq.dat[7:0];
      end
      if (wbReq.adr == `ART_OFF_PWM_CONTROL_REG) begin
        pwmCtl_r <= wbReq.dat[7:0];
      end
    end
  end

  // Overflow flag: a new overflow wins over the clearing read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflowFlag_r <= 1'b0;
    end else if (overflow) begin
      overflowFlag_r <= 1'b1;
    end else if (rdStb && (wbReq.adr == `ART_OFF_CSR)) begin
      overflowFlag_r <= 1'b0;
    end
  end

  assign irqReq  = overflowFlag_r && ctrl_r.overflowIrqEnable;
  assign wakeReq = irqReq && (waitMode || haltMode);

  // Per-channel duty, hidden compare and raw wave
  genvar ch;
  generate
    for (ch = 0; ch < `ART_NCH; ch++) begin : gChan
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          dutyReg_r[ch] <= `ART_RST_BYTE;
        end else if (wrStb && (wbReq.adr == (`ART_OFF_DCR0 + 8'(ch * 4)))) begin
          dutyReg_r[ch] <= wbReq.dat[7:0];
        end
      end
      // Loading only at overflow keeps a duty change from cutting a period short
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          hiddenCmp_r[ch] <= `ART_RST_BYTE;
        end else if (overflow) begin
          hiddenCmp_r[ch] <= dutyReg_r[ch];
        end
      end
      // Raw wave is the polarity-0 form; it is held while HALT stops ticks
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          waveRaw_r[ch] <= 1'b0;
        end else if (overflow || forceReload || carWrite) begin
          waveRaw_r[ch] <= 1'b1;
        end else if (counterTick && (counter_r == hiddenCmp_r[ch])) begin
          waveRaw_r[ch] <= 1'b0;
        end
      end
      // Polarity applied after the flop so a change shows at once
      assign pwmOutPin[ch]   = pwmCtl_r.channelOutputEnable[ch] &
                               (waveRaw_r[ch] ^ pwmCtl_r.channelPolarity[ch]);
      assign pwmOutPinOe[ch] = pwmCtl_r.channelOutputEnable[ch];
    end
  endgenerate

  // Read mux; prescaler is not mapped and force reload reads zero
  always_comb begin
    rdData = `ART_UNMAPPED;
    unique case (wbReq.adr)
      `ART_OFF_CSR:   rdData = {24'h000000, ctrl_r.extClockSelect,
                                ctrl_r.counterClockDivider, ctrl_r.countEnableBit,
                                1'b0, ctrl_r.overflowIrqEnable, overflowFlag_r};
      `ART_OFF_CAR:   rdData = {24'h000000, counter_r};
      `ART_OFF_ARR:   rdData = {24'h000000, reload_r};
      `ART_OFF_PWM_CONTROL_REG: rdData = {24'h000000, pwmCtl_r};
      `ART_OFF_DCR0:  rdData = {24'h000000, dutyReg_r[0]};
      `ART_OFF_DCR1:  rdData = {24'h000000, dutyReg_r[1]};
      `ART_OFF_DCR2:  rdData = {24'h000000, dutyReg_r[2]};
      `ART_OFF_DCR3:  rdData = {24'h000000, dutyReg_r[3]};
      default:        rdData = `ART_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wbAck  <= 1'b0;
      wbDatO <= `ART_UNMAPPED;
    end else begin
      wbAck <= access;
      if (rdStb) begin
        wbDatO <= rdData;
      end
    end
  end
endmodule
